/* logic/wiper_step_and_lock_commands.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - increment and decrement change wiper values only at volatile wiper addresses 00h, 01h, 06h, 07h
// - step to nonvolatile address, unless high-voltage lock/protect, is refused with NACK
// - increment adds one, saturating at 100h (8-bit) or 80h (7-bit)
// - decrement subtracts one, saturating at zero
// - wiper output updates at each command acknowledge
// - step commands chain until Stop, except that any valid command after a lock/protect step is refused with NACK
// - addresses 00h, 01h, 06h, 07h step wipers 0, 1, 2, 3
// - high-voltage decrement to 02h/03h/08h/09h locks, increment unlocks that wiper
// - high-voltage decrement to 0Fh enables write protect, increment disables it
// - steps to 04h/05h/0Ah change nothing; 0Bh-0Eh are invalid
// - high-voltage pin level marks a command as high-voltage; only those modify locks
// - lock/protect write cycle starts only after full command and Stop
// - during write cycle only 00h, 01h, 04h, 05h are accepted
// - write-active flag shows a write cycle in progress
// - invalid command releases the line and ignores the bus until Start
module wiper_step_and_lock_commands (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_hv_or_addr0_pin,
    input wire logic i_eight_bit_part,
    input wire logic i_start,
    input wire logic i_stop,
    input wire wiper_cmd_pkg::cmd_t i_cmd,
    input wire logic i_ee_done,
    output wiper_cmd_pkg::ack_t o_ack,
    output logic [3:0][8:0] o_wiper,
    output logic [3:0] o_lock,
    output logic o_wprot,
    output logic o_eeprom_write_active,
    output logic o_ee_start
);

    wiper_cmd_pkg::exec_state_t q;
    wiper_cmd_pkg::exec_state_t d;
    logic [8:0] step_in;
    logic [8:0] step_out;
    logic [8:0] full_scale;
    logic is_step;

    function automatic logic is_wiper_addr(input logic [3:0] a);
        return a == wiper_cmd_pkg::ADDR_WIPER0 || a == wiper_cmd_pkg::ADDR_WIPER1 ||
               a == wiper_cmd_pkg::ADDR_WIPER2 || a == wiper_cmd_pkg::ADDR_WIPER3;
    endfunction

    function automatic logic [1:0] wiper_index(input logic [3:0] a);
        unique case (a)
            wiper_cmd_pkg::ADDR_WIPER1: return 2'h1;
            wiper_cmd_pkg::ADDR_WIPER2: return 2'h2;
            wiper_cmd_pkg::ADDR_WIPER3: return 2'h3;
            default: return 2'h0;
        endcase
    endfunction

    // target 0..3 are wiper locks, 4 is write protect, 7 means not a modify address
    function automatic logic [2:0] modify_target(input logic [3:0] a);
        unique case (a)
            wiper_cmd_pkg::ADDR_LOCK0: return 3'h0;
            wiper_cmd_pkg::ADDR_LOCK1: return 3'h1;
            wiper_cmd_pkg::ADDR_LOCK2: return 3'h2;
            wiper_cmd_pkg::ADDR_LOCK3: return 3'h3;
            wiper_cmd_pkg::ADDR_WRITE_PROTECT: return 3'h4;
            default: return 3'h7;
        endcase
    endfunction

    function automatic logic passive_addr(input logic [3:0] a);
        return a == wiper_cmd_pkg::ADDR_TERMINAL_CONTROL_0 || a == wiper_cmd_pkg::ADDR_DEVICE_STATUS ||
               a == wiper_cmd_pkg::ADDR_TERMINAL_CONTROL_1;
    endfunction

    function automatic logic busy_allowed(input logic [3:0] a);
        return a == wiper_cmd_pkg::ADDR_WIPER0 || a == wiper_cmd_pkg::ADDR_WIPER1 ||
               a == wiper_cmd_pkg::ADDR_TERMINAL_CONTROL_0 || a == wiper_cmd_pkg::ADDR_DEVICE_STATUS;
    endfunction

    assign full_scale = i_eight_bit_part ? wiper_cmd_pkg::FULL_SCALE_8BIT : wiper_cmd_pkg::FULL_SCALE_7BIT;
    assign step_in = q.wiper[wiper_index(i_cmd.addr)];
    // outside MODE_NV_PENDING, read and write opcodes belong to other command paths and pass untouched
    assign is_step = i_cmd.valid &&
                     (i_cmd.opcode == wiper_cmd_pkg::OP_INCREMENT ||
                      i_cmd.opcode == wiper_cmd_pkg::OP_DECREMENT);

    wiper_step u_step (
        .i_value(step_in),
        .i_up(i_cmd.opcode == wiper_cmd_pkg::OP_INCREMENT),
        .i_full_scale(full_scale),
        .o_value(step_out)
    );

    always_comb begin
        d = q;
        d.ack = '0;
        d.ee_start = 1'h0;
        d.hv_meta = i_hv_or_addr0_pin;
        d.hv_level = q.hv_meta;
        if (i_ee_done) begin
            d.eeprom_write_active = 1'h0;
        end
        unique case (q.mode)
            wiper_cmd_pkg::MODE_FALLEN_OFF: begin
                if (i_start) begin
                    d.mode = wiper_cmd_pkg::MODE_IDLE;
                end else if (is_step) begin
                    d.ack.valid = 1'h1;
                end
            end
            wiper_cmd_pkg::MODE_NV_PENDING: begin
                if (i_stop) begin
                    // commit only now, so a torn frame never burns the eeprom
                    d.mode = wiper_cmd_pkg::MODE_IDLE;
                    d.eeprom_write_active = 1'h1;
                    d.ee_start = 1'h1;
                    if (q.pend_target == 3'h4) begin
                        d.wprot = q.pend_set;
                    end else begin
                        d.lock[q.pend_target[1:0]] = q.pend_set;
                    end
                end else if (i_start) begin
                    d.mode = wiper_cmd_pkg::MODE_IDLE;
                end else if (i_cmd.valid) begin
                    d.ack.valid = 1'h1;
                    d.mode = wiper_cmd_pkg::MODE_FALLEN_OFF;
                end
            end
            wiper_cmd_pkg::MODE_IDLE: begin
                if (is_step) begin
                    d.ack.valid = 1'h1;
                    if (q.eeprom_write_active && !busy_allowed(i_cmd.addr)) begin
                        d.ack.ok = 1'h0;
                    end else if (is_wiper_addr(i_cmd.addr)) begin
                        d.ack.ok = 1'h1;
                        d.wiper[wiper_index(i_cmd.addr)] = step_out;
                    end else if (passive_addr(i_cmd.addr)) begin
                        d.ack.ok = 1'h1;
                    end else if (q.hv_level && modify_target(i_cmd.addr) != 3'h7) begin
                        d.ack.ok = 1'h1;
                        d.pend_set = i_cmd.opcode == wiper_cmd_pkg::OP_DECREMENT;
                        d.pend_target = modify_target(i_cmd.addr);
                        d.mode = wiper_cmd_pkg::MODE_NV_PENDING;
                    end else begin
                        d.ack.ok = 1'h0;
                        d.mode = wiper_cmd_pkg::MODE_FALLEN_OFF;
                    end
                end
            end
            default: begin
                // the unused mode code recovers to idle
                d.mode = wiper_cmd_pkg::MODE_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            q.mode <= wiper_cmd_pkg::MODE_IDLE;
            q.wiper <= {wiper_cmd_pkg::WIPER_COUNT{wiper_cmd_pkg::WIPER_RESET}};
            q.lock <= wiper_cmd_pkg::LOCK_RESET;
            q.wprot <= wiper_cmd_pkg::WPROT_RESET;
            q.eeprom_write_active <= 1'h0;
            q.ee_start <= 1'h0;
            q.ack <= '0;
            q.pend_set <= 1'h0;
            q.pend_target <= 3'h0;
            q.hv_meta <= 1'h0;
            q.hv_level <= 1'h0;
        end else begin
            q <= d;
        end
    end

    assign o_ack = q.ack;
    assign o_wiper = q.wiper;
    assign o_lock = q.lock;
    assign o_wprot = q.wprot;
    assign o_eeprom_write_active = q.eeprom_write_active;
    assign o_ee_start = q.ee_start;

endmodule

/* pkg/wiper_cmd_pkg.sv */
package wiper_cmd_pkg;

    localparam logic [3:0] ADDR_WIPER0 = 4'h0;
    localparam logic [3:0] ADDR_WIPER1 = 4'h1;
    localparam logic [3:0] ADDR_LOCK0 = 4'h2;
    localparam logic [3:0] ADDR_LOCK1 = 4'h3;
    localparam logic [3:0] ADDR_TERMINAL_CONTROL_0 = 4'h4;
    localparam logic [3:0] ADDR_DEVICE_STATUS = 4'h5;
    localparam logic [3:0] ADDR_WIPER2 = 4'h6;
    localparam logic [3:0] ADDR_WIPER3 = 4'h7;
    localparam logic [3:0] ADDR_LOCK2 = 4'h8;
    localparam logic [3:0] ADDR_LOCK3 = 4'h9;
    localparam logic [3:0] ADDR_TERMINAL_CONTROL_1 = 4'hA;
    localparam logic [3:0] ADDR_WRITE_PROTECT = 4'hF;

    // command-byte opcodes; plain defaults, to be aligned with the command decoder
    localparam logic [1:0] OP_WRITE = 2'h0;
    localparam logic [1:0] OP_INCREMENT = 2'h1;
    localparam logic [1:0] OP_DECREMENT = 2'h2;
    localparam logic [1:0] OP_READ = 2'h3;

    localparam int WIPER_COUNT = 4;
    localparam int WIPER_WIDTH = 9;
    localparam logic [8:0] FULL_SCALE_8BIT = 9'h100;
    localparam logic [8:0] FULL_SCALE_7BIT = 9'h080;
    localparam logic [8:0] ZERO_SCALE = 9'h000;
    localparam logic [8:0] WIPER_RESET = 9'h080;
    localparam logic [3:0] LOCK_RESET = 4'h0;
    localparam logic WPROT_RESET = 1'h0;

    typedef enum logic [1:0] {
        MODE_IDLE,
        MODE_NV_PENDING,
        MODE_FALLEN_OFF
    } cmd_mode_t;

    typedef struct packed {
        logic valid;
        logic [3:0] addr;
        logic [1:0] opcode;
    } cmd_t;

    typedef struct packed {
        logic valid;
        logic ok;
    } ack_t;

    typedef struct packed {
        cmd_mode_t mode;
        logic [WIPER_COUNT-1:0][WIPER_WIDTH-1:0] wiper;
        logic [WIPER_COUNT-1:0] lock;
        logic wprot;
        logic eeprom_write_active;
        logic ee_start;
        ack_t ack;
        logic pend_set;
        logic [2:0] pend_target;
        logic hv_meta;
        logic hv_level;
    } exec_state_t;

endpackage

/* logic/wiper_step.sv */
`timescale 1ns/1ps
module wiper_step (
    input wire logic [8:0] i_value,
    input wire logic i_up,
    input wire logic [8:0] i_full_scale,
    output logic [8:0] o_value
);

    always_comb begin
        if (i_up) begin
            // full scale and reserved codes never climb further
            if (i_value >= i_full_scale) begin
                o_value = i_value;
            end else begin
                o_value = i_value + 9'h001;
            end
        end else begin
            // a reserved code is left alone rather than pulled back into range
            if (i_value == wiper_cmd_pkg::ZERO_SCALE || i_value > i_full_scale) begin
                o_value = i_value;
            end else begin
                o_value = i_value - 9'h001;
            end
        end
    end

endmodule

/* verif/i2c_host_model.sv */
`timescale 1ns/1ps
module i2c_host_model (
    input wire logic i_clk,
    output logic o_hv,
    output logic o_start,
    output logic o_stop,
    output wiper_cmd_pkg::cmd_t o_cmd
);
    initial begin
        o_hv = 1'h0;
        o_start = 1'h0;
        o_stop = 1'h0;
        o_cmd = '0;
    end
    // one decoded command byte; strings run on until a stop pulse
    task automatic send(input logic [3:0] addr, input logic [1:0] op);
        @(posedge i_clk);
        o_cmd <= '{1'h1, addr, op};
        @(posedge i_clk);
        o_cmd <= '0;
    endtask
    task automatic pulse(input logic stop);
        @(posedge i_clk);
        o_stop <= stop;
        o_start <= !stop;
        @(posedge i_clk);
        o_stop <= 1'h0;
        o_start <= 1'h0;
    endtask
    // settle time before the first command, longer than the synchroniser
    task automatic drive_hv(input logic lvl);
        @(posedge i_clk);
        o_hv <= lvl;
        repeat (3) @(posedge i_clk);
    endtask
endmodule

/* verif/wiper_step_and_lock_commands_monitor.sv */
`timescale 1ns/1ps
module wiper_step_and_lock_commands_monitor (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_hv_or_addr0_pin,
    input wire logic i_eight_bit_part,
    input wire logic i_start,
    input wire logic i_stop,
    input wire wiper_cmd_pkg::cmd_t i_cmd,
    input wire logic i_ee_done,
    input wire wiper_cmd_pkg::ack_t o_ack,
    input wire logic [3:0][8:0] o_wiper,
    input wire logic [3:0] o_lock,
    input wire logic o_wprot,
    input wire logic o_eeprom_write_active,
    input wire logic o_ee_start
);
    default clocking @(posedge i_clk);
    endclocking
    default disable iff (i_rst);
    logic up, dn, st;
    logic [8:0] fs;
    assign up = i_cmd.valid && i_cmd.opcode == wiper_cmd_pkg::OP_INCREMENT;
    assign dn = i_cmd.valid && i_cmd.opcode == wiper_cmd_pkg::OP_DECREMENT;
    assign st = up || dn;
    assign fs = i_eight_bit_part ? 9'h100 : 9'h080;
    a_answer_next: assert property (st |=> o_ack.valid) else $error("no answer");
    a_inc_by_one: assert property (up && i_cmd.addr == 4'h1 && o_wiper[1] < fs
        |=> !o_ack.ok || o_wiper[1] == $past(o_wiper[1]) + 9'h001) else $error("bad step");
    a_inc_cap: assert property (up && i_cmd.addr == 4'h0 && o_wiper[0] >= fs |=> $stable(o_wiper[0]))
        else $error("passed full scale");
    a_dec_floor: assert property (dn && i_cmd.addr == 4'h7 && o_wiper[3] == 9'h000
        |=> o_wiper[3] == 9'h000) else $error("passed zero");
    a_reserved_nack: assert property (st && i_cmd.addr > 4'hA && i_cmd.addr < 4'hF |=> !o_ack.ok)
        else $error("reserved taken");
    a_lock_needs_hv: assert property (st && i_cmd.addr == 4'h2 && !i_hv_or_addr0_pin
        && !$past(i_hv_or_addr0_pin) && !$past(i_hv_or_addr0_pin, 2) |=> !o_ack.ok) else $error("lock without hv");
    a_commit_after_stop: assert property ($rose(o_ee_start) |-> $past(i_stop)) else $error("early write");
    a_lock_at_commit: assert property ($changed(o_lock) |-> o_ee_start) else $error("lock moved");
    a_busy_flag: assert property (o_ee_start |-> o_eeprom_write_active) else $error("busy flag low");
    a_busy_gate: assert property (o_eeprom_write_active && st && i_cmd.addr == 4'h6 |=> !o_ack.ok) else $error("busy taken");
endmodule
bind wiper_step_and_lock_commands wiper_step_and_lock_commands_monitor i_mon (.*);

/* verif/wiper_step_and_lock_commands_tb.sv */
`timescale 1ns/1ps
module wiper_step_and_lock_commands_tb;
    logic i_clk, i_rst, i_eight_bit_part, i_ee_done, hv, start, stop, o_wprot, o_eeprom_write_active, o_ee_start;
    wiper_cmd_pkg::cmd_t cmd;
    wiper_cmd_pkg::ack_t o_ack;
    logic [3:0][8:0] o_wiper;
    logic [3:0] o_lock, la [4];
    logic [4:0] prot;
    logic [8:0] w [4];
    int bad_count, compares;
    i2c_host_model i_i2c_host_model (.i_clk(i_clk), .o_hv(hv), .o_start(start), .o_stop(stop), .o_cmd(cmd));
    wiper_step_and_lock_commands i_wiper_step_and_lock_commands (.i_clk(i_clk), .i_rst(i_rst),
        .i_hv_or_addr0_pin(hv), .i_eight_bit_part(i_eight_bit_part), .i_start(start), .i_stop(stop),
        .i_cmd(cmd), .i_ee_done(i_ee_done), .o_ack(o_ack), .o_wiper(o_wiper), .o_lock(o_lock),
        .o_wprot(o_wprot), .o_eeprom_write_active(o_eeprom_write_active), .o_ee_start(o_ee_start));
    task automatic check(input string name, input logic [8:0] seen, input logic [8:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic end_sim;
        if (bad_count == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic step(input logic [3:0] a, input logic up, input logic ok);
        int n;
        logic [8:0] fs;
        fs = i_eight_bit_part ? 9'h100 : 9'h080;
        n = a == 4'h0 ? 0 : a == 4'h1 ? 1 : a == 4'h6 ? 2 : a == 4'h7 ? 3 : -1;
        i_i2c_host_model.send(a, up ? wiper_cmd_pkg::OP_INCREMENT : wiper_cmd_pkg::OP_DECREMENT);
        #1;
        check("ack", {7'h00, o_ack}, {7'h01, ok});
        if (ok && n >= 0) begin
            if (up && w[n] < fs) w[n] = w[n] + 9'h001;
            if (!up && w[n] != 9'h000) w[n] = w[n] - 9'h001;
        end
        for (int i = 0; i < 4; i++) check("wiper", o_wiper[i], w[i]);
    endtask
    // a modify only lands at stop; the busy window is probed before releasing it
    task automatic modify(input logic [3:0] a, input logic up);
        step(a, up, 1'h1);
        i_i2c_host_model.pulse(1'h1);
        #1;
        check("start_pulse", {8'h00, o_ee_start}, 9'h001);
        @(posedge i_clk);
        #1;
        check("protect", {4'h0, o_wprot, o_lock}, {4'h0, prot});
        check("busy", {8'h00, o_eeprom_write_active}, 9'h001);
        check("start_end", {8'h00, o_ee_start}, 9'h000);
        step(4'h6, 1'h1, 1'h0);
        step(4'h0, 1'h0, 1'h1);
        @(posedge i_clk);
        i_ee_done <= 1'h1;
        @(posedge i_clk);
        i_ee_done <= 1'h0;
        @(posedge i_clk);
        #1;
        check("idle", {8'h00, o_eeprom_write_active}, 9'h000);
    endtask
    initial begin
        i_clk = 1'h0;
        forever #50 i_clk = ~i_clk;
    end
    initial begin
        repeat (50000) @(posedge i_clk);
        bad_count++;
        end_sim;
    end
    initial begin
        i_rst = 1'h1;
        i_eight_bit_part = 1'h0;
        i_ee_done = 1'h0;
        bad_count = 0;
        compares = 0;
        prot = 5'h00;
        la = '{4'h2, 4'h3, 4'h8, 4'h9};
        for (int i = 0; i < 4; i++) w[i] = 9'h080;
        repeat (5) @(posedge i_clk);
        i_rst <= 1'h0;
        #1;
        check("reset", {3'h0, o_wprot, o_eeprom_write_active, o_lock}, 9'h000);
        step(4'h0, 1'h1, 1'h1);
        step(4'h0, 1'h0, 1'h1);
        step(4'h0, 1'h1, 1'h1);
        @(posedge i_clk);
        i_eight_bit_part <= 1'h1;
        for (int k = 0; k < 9'h081; k++) step(4'h7, 1'h0, 1'h1);
        for (int k = 0; k < 9'h101; k++) step(4'h7, 1'h1, 1'h1);
        foreach (la[k]) step(la[k] ^ 4'h3 ? 4'h1 : 4'h6, 1'h1, 1'h1);
        step(4'h4, 1'h0, 1'h1);
        step(4'h5, 1'h1, 1'h1);
        step(4'hA, 1'h0, 1'h1);
        step(4'h2, 1'h0, 1'h0);
        i_i2c_host_model.pulse(1'h0);
        step(4'hC, 1'h1, 1'h0);
        i_i2c_host_model.pulse(1'h0);
        i_i2c_host_model.drive_hv(1'h1);
        for (int k = 0; k < 4; k++) begin
            prot[k] = 1'h1;
            modify(la[k], 1'h0);
        end
        prot[4] = 1'h1;
        modify(4'hF, 1'h0);
        prot[4] = 1'h0;
        modify(4'hF, 1'h1);
        prot[2] = 1'h0;
        modify(4'h8, 1'h1);
        step(4'h9, 1'h1, 1'h1);
        step(4'h1, 1'h1, 1'h0);
        i_i2c_host_model.pulse(1'h1);
        @(posedge i_clk);
        #1;
        check("dropped", {3'h0, o_eeprom_write_active, o_wprot, o_lock}, {4'h0, prot});
        end_sim;
    end
endmodule
